// *** core/hrs_upload.sv ***
// Overview of operation
// - end record: length 00, exec address, type 01
// - loaded file sets program counter from exec address
// - cassette file opens with file-number record, type 02
// - line front end RS-232 or current loop
// - character engine: dedicated controller or internal unit
// - timer reprogrammed on each new rate
// - rates 110 to 9600 baud only
// - selected rate readable unchanged
// - divisors assume 6 MHz reference
// - reset rate is 2400 baud
// - upload partition within user memory, sent as data
// - lowest partition address is load address
// - program counter at start is exec address
// - upload start turns listing off
// - loading shown until whole file sent
// - handshake looped locally, optionally external
// - data record: count, address, type 00, max sixteen
// - checksum is low byte of byte sum
// - two frames per byte, colon first
// - ASCII hex frames, control-Z ends file except in cassette mode
`include "hrs_consts.svh"
module hrs_upload #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        i_clk,          // 200 MHz clock
    input  wire logic        i_rst_b,        // async reset, low
    input  wire logic        i_start,        // upload request pulse
    input  wire logic        i_cassette,     // emit file-number record
    input  wire logic [15:0] i_file_num,     // cassette file number
    input  wire logic [15:0] i_part_lo,      // partition first address
    input  wire logic [15:0] i_part_hi,      // partition last address
    input  wire logic [15:0] i_pc,           // current program counter
    output logic [15:0]      o_mem_addr,     // memory read address
    input  wire logic [7:0]  i_mem_data,     // memory byte, same cycle
    input  wire logic        i_load_done,    // received file finished, pulse
    input  wire logic [15:0] i_load_exec,    // exec address of received file
    output logic [15:0]      o_program_counter, // program counter
    input  wire logic        i_list_on,      // set listing on, pulse
    output logic             o_list_mode,    // listing mode
    input  wire logic        i_rate_wr,      // rate write pulse
    input  wire logic [2:0]  i_rate_sel,     // rate code 0..6
    output logic [2:0]       o_rate_sel,     // rate code read back
    input  wire logic        i_line_sel,     // 0 RS-232, 1 loop
    input  wire logic        i_engine_sel,   // 0 dedicated, 1 internal
    input  wire logic        i_int_txd,      // internal unit serial out
    input  wire logic        i_ext_hs,       // use external handshake
    input  wire logic        i_cts_b,        // clear to send, low (pin)
    output logic             o_rts_b,        // request to send, low
    output logic             o_txd_rs232,    // RS-232 data out
    output logic             o_txd_loop,     // current loop data out
    output logic             o_bit_rate_clock, // timer output, 16x
    output logic             o_loading,      // loading shown
    output logic             o_bad_part      // partition refused
);
    // timer divisors, 16x clock from 6 MHz reference (half periods)
    function automatic logic [15:0] hrs_div(input logic [2:0] code);
        case (code)
            3'h0: hrs_div = 16'(`HRS_REF_HZ / (110 * 32));
            3'h1: hrs_div = 16'(`HRS_REF_HZ / (300 * 32));
            3'h2: hrs_div = 16'(`HRS_REF_HZ / (600 * 32));
            3'h3: hrs_div = 16'(`HRS_REF_HZ / (1200 * 32));
            3'h4: hrs_div = 16'(`HRS_REF_HZ / (2400 * 32));
            3'h5: hrs_div = 16'(`HRS_REF_HZ / (4800 * 32));
            default: hrs_div = 16'(`HRS_REF_HZ / (9600 * 32));
        endcase
    endfunction : hrs_div
    // nibble to ASCII hex
    function automatic logic [7:0] hrs_hex(input logic [3:0] n);
        hrs_hex = (n < 4'hA) ? 8'h30 + {4'h0, n} : 8'h37 + {4'h0, n};
    endfunction : hrs_hex

    // reference tick from system clock: 200/6 approx by fraction
    localparam logic [7:0] REF_NUM = 8'h03;          // 6/200 = 3/100
    localparam logic [7:0] REF_DEN = 8'h64;

    // all state in one struct
    typedef struct packed {
        hrs_pkg::hrs_state_t state;   // sequencer
        hrs_pkg::hrs_rec_t   rec;     // record kind
        logic [15:0] addr;            // next byte address
        logic [15:0] hi;              // last partition byte
        logic [15:0] exec;            // latched exec address
        logic [15:0] fnum;            // file number
        logic [4:0]  len;             // bytes in current record
        logic [4:0]  idx;             // byte index within field
        logic        nib;             // 0 high frame, 1 low frame
        logic [7:0]  sum;             // running byte sum
        logic [15:0] pc;              // program counter
        logic        list;            // listing mode
        logic [2:0]  rate;            // selected rate code
        logic [15:0] div;             // timer reload
        logic [15:0] tcnt;            // timer count
        logic [7:0]  frac;            // reference accumulator
        logic        bclk;            // bit rate clock
        logic        bclk_d;          // edge detect
        logic [3:0]  sub;             // 16x sub count
        logic [9:0]  shreg;           // tx shift
        logic [3:0]  bits;            // bits left
        logic        txd;             // dedicated engine out
        logic        cts_s1;          // sync stage 1
        logic        cts_s2;          // sync stage 2
        logic        int_s1;          // sync stage 1
        logic        int_s2;          // sync stage 2
        logic        txd_rs;          // rs232 pin
        logic        txd_lp;          // loop pin
        logic        loading;         // loading indicator
        logic        bad;             // refused partition
        logic        rts_b;           // request to send, low
    } hrs_st_t;
    hrs_st_t st, next_st;

    // character fifo between framer and shifter
    logic [7:0] f_in;
    logic       f_in_v, f_rdy, f_out_v, f_take;
    logic [7:0] f_out;
    hrs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_data  (f_in),
        .i_valid (f_in_v),
        .o_ready (f_rdy),
        .o_data  (f_out),
        .o_valid (f_out_v),
        .i_ready (f_take)
    );

    logic [7:0] cur_byte;     // byte being framed
    logic       clr;          // handshake permits sending
    logic       btick;        // one bit period elapsed
    logic [15:0] left;        // bytes remaining minus one

    // byte selection for header/data fields
    always_comb
    begin
        cur_byte = 8'h00;
        left = st.hi - st.addr;
        case (st.state)
            hrs_pkg::HRS_HDR:
                case (st.idx[1:0])
                    2'h0: cur_byte = {3'h0, st.len};
                    2'h1: cur_byte = (st.rec == hrs_pkg::HRS_REC_DATA) ? st.addr[15:8] :
                                     (st.rec == hrs_pkg::HRS_REC_EOF) ? st.exec[15:8] : st.fnum[15:8];
                    2'h2: cur_byte = (st.rec == hrs_pkg::HRS_REC_DATA) ? st.addr[7:0] :
                                     (st.rec == hrs_pkg::HRS_REC_EOF) ? st.exec[7:0] : st.fnum[7:0];
                    default: cur_byte = (st.rec == hrs_pkg::HRS_REC_DATA) ? `HRS_TYPE_DATA :
                                        (st.rec == hrs_pkg::HRS_REC_EOF) ? `HRS_TYPE_EOF :
                                        `HRS_TYPE_FILENUM;
                endcase
            hrs_pkg::HRS_DATA: cur_byte = i_mem_data;
            hrs_pkg::HRS_SUM:  cur_byte = st.sum;
            default: cur_byte = 8'h00;
        endcase
    end

    assign clr    = i_ext_hs ? !st.cts_s2 : 1'b1;
    assign btick  = (st.bclk && !st.bclk_d) && (st.sub == 4'hF);
    assign f_take = btick && f_out_v && clr && (st.bits == 4'h0);  // empty fifo never framed
    assign f_in   = (st.state == hrs_pkg::HRS_MARK) ? `HRS_CHAR_COLON :
                    (st.state == hrs_pkg::HRS_CR)   ? `HRS_CHAR_CR :
                    (st.state == hrs_pkg::HRS_LF)   ? `HRS_CHAR_LF :
                    (st.state == hrs_pkg::HRS_EOFZ) ? `HRS_CHAR_CTRLZ :
                    hrs_hex(st.nib ? cur_byte[3:0] : cur_byte[7:4]);
    assign f_in_v = (st.state != hrs_pkg::HRS_IDLE) && (st.state != hrs_pkg::HRS_DONE);

    // sequencer, timer, shifter
    always_comb
    begin
        next_st = st;
        next_st.cts_s1 = i_cts_b;
        next_st.cts_s2 = st.cts_s1;
        next_st.int_s1 = i_int_txd;
        next_st.int_s2 = st.int_s1;
        next_st.bclk_d = st.bclk;
        // rate selection, out-of-range codes refused
        if (i_rate_wr && i_rate_sel <= 3'h6)
        begin
            next_st.rate = i_rate_sel;
            next_st.div  = hrs_div(i_rate_sel);
            next_st.tcnt = 16'h0000;
        end
        else
        begin
            // reference tick at 6 MHz average, then timer
            if (st.frac + REF_NUM >= REF_DEN)
            begin
                next_st.frac = st.frac + REF_NUM - REF_DEN;
                if (st.tcnt + 16'h0001 >= st.div)
                begin
                    next_st.tcnt = 16'h0000;
                    next_st.bclk = !st.bclk;
                end
                else
                    next_st.tcnt = st.tcnt + 16'h0001;
            end
            else
                next_st.frac = st.frac + REF_NUM;
        end
        // shifter, 8N1 LSB first at 1/16 of the bit clock
        if (st.bclk && !st.bclk_d)
            next_st.sub = st.sub + 4'h1;
        if (f_take)
        begin
            next_st.shreg = {1'b1, f_out, 1'b0};
            next_st.bits  = `HRS_CHAR_BITS;
        end
        else if (btick && st.bits != 4'h0)
        begin
            next_st.txd   = st.shreg[0];
            next_st.shreg = {1'b1, st.shreg[9:1]};
            next_st.bits  = st.bits - 4'h1;
        end
        // engine then line front end
        next_st.txd_rs = (i_line_sel == 1'(hrs_pkg::HRS_LINE_RS232)) ?
                         (i_engine_sel ? st.int_s2 : st.txd) : 1'b1;
        next_st.txd_lp = (i_line_sel == 1'(hrs_pkg::HRS_LINE_LOOP)) ?
                         (i_engine_sel ? st.int_s2 : st.txd) : 1'b1;
        // listing mode and received file
        if (i_list_on)
            next_st.list = 1'b1;
        if (i_load_done)
            next_st.pc = i_load_exec;
        else
            next_st.pc = i_pc;
        // framer
        if (f_in_v && f_rdy && st.state inside {hrs_pkg::HRS_HDR, hrs_pkg::HRS_DATA, hrs_pkg::HRS_SUM})
        begin
            if (st.nib && st.state != hrs_pkg::HRS_SUM)
                next_st.sum = st.sum + cur_byte;
        end
        case (st.state)
            hrs_pkg::HRS_IDLE:
                if (i_start)
                begin
                    next_st.list = 1'b0;
                    if (i_part_hi > `HRS_USER_TOP || i_part_lo > i_part_hi)
                        next_st.bad = 1'b1;
                    else
                    begin
                        next_st.bad     = 1'b0;
                        next_st.addr    = i_part_lo;
                        next_st.hi      = i_part_hi;
                        next_st.exec    = i_pc;
                        next_st.fnum    = i_file_num;
                        next_st.loading = 1'b1;
                        next_st.rec     = i_cassette ? hrs_pkg::HRS_REC_FNUM : hrs_pkg::HRS_REC_DATA;
                        next_st.len     = 5'h00;
                        next_st.state   = hrs_pkg::HRS_MARK;
                    end
                end
            hrs_pkg::HRS_MARK:
                if (f_rdy)
                begin
                    // size this record, at most sixteen, ascending
                    if (st.rec == hrs_pkg::HRS_REC_DATA)
                        next_st.len = (left >= 16'h000F) ? `HRS_MAX_DATA : 5'(left + 16'h0001);
                    else
                        next_st.len = 5'h00;
                    next_st.sum   = 8'h00;
                    next_st.idx   = 5'h00;
                    next_st.nib   = 1'b0;
                    next_st.state = hrs_pkg::HRS_HDR;
                end
            hrs_pkg::HRS_HDR:
                if (f_rdy)
                begin
                    next_st.nib = !st.nib;
                    if (st.nib)
                    begin
                        next_st.idx = st.idx + 5'h01;
                        if (st.idx == 5'h03)
                        begin
                            next_st.idx   = 5'h00;
                            next_st.state = (st.len == 5'h00) ? hrs_pkg::HRS_SUM : hrs_pkg::HRS_DATA;
                        end
                    end
                end
            hrs_pkg::HRS_DATA:
                if (f_rdy)
                begin
                    next_st.nib = !st.nib;
                    if (st.nib)
                    begin
                        next_st.addr = st.addr + 16'h0001;
                        next_st.idx  = st.idx + 5'h01;
                        if (st.idx + 5'h01 == st.len)
                            next_st.state = hrs_pkg::HRS_SUM;
                    end
                end
            hrs_pkg::HRS_SUM:
                if (f_rdy)
                begin
                    next_st.nib = !st.nib;
                    if (st.nib)
                        next_st.state = hrs_pkg::HRS_CR;
                end
            hrs_pkg::HRS_CR:
                if (f_rdy)
                    next_st.state = hrs_pkg::HRS_LF;
            hrs_pkg::HRS_LF:
                if (f_rdy)
                begin
                    next_st.state = hrs_pkg::HRS_MARK;
                    if (st.rec == hrs_pkg::HRS_REC_EOF)
                        next_st.state = i_cassette ? hrs_pkg::HRS_DONE : hrs_pkg::HRS_EOFZ;
                    else if (st.rec == hrs_pkg::HRS_REC_FNUM)
                        next_st.rec = hrs_pkg::HRS_REC_DATA;
                    else if (st.addr > st.hi || st.addr == 16'h0000)
                        next_st.rec = hrs_pkg::HRS_REC_EOF;
                end
            hrs_pkg::HRS_EOFZ:
                if (f_rdy)
                    next_st.state = hrs_pkg::HRS_DONE;
            hrs_pkg::HRS_DONE:
                // prompt only after last character left the line
                if (!f_out_v && st.bits == 4'h0)
                begin
                    next_st.loading = 1'b0;
                    next_st.state   = hrs_pkg::HRS_IDLE;
                end
            default: next_st.state = hrs_pkg::HRS_IDLE;
        endcase
        next_st.rts_b = !next_st.loading;
    end

    // state register, reset defaults
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            st        <= '0;
            st.rts_b  <= 1'b1;
            st.rate   <= `HRS_RATE_RESET;
            st.div    <= 16'(`HRS_REF_HZ / (2400 * 32));
            st.txd    <= 1'b1;
            st.txd_rs <= 1'b1;
            st.txd_lp <= 1'b1;
            st.shreg  <= 10'h3FF;
            st.cts_s1 <= 1'b1;
            st.cts_s2 <= 1'b1;
            st.int_s1 <= 1'b1;
            st.int_s2 <= 1'b1;
        end
        else
            st <= next_st;
    end

    // outputs, all registered
    assign o_mem_addr        = st.addr;
    assign o_program_counter = st.pc;
    assign o_list_mode       = st.list;
    assign o_rate_sel        = st.rate;
    assign o_rts_b           = st.rts_b;     // asserted while sending
    assign o_txd_rs232       = st.txd_rs;
    assign o_txd_loop        = st.txd_lp;
    assign o_bit_rate_clock  = st.bclk;
    assign o_loading         = st.loading;
    assign o_bad_part        = st.bad;
endmodule : hrs_upload

// *** core/hrs_consts.svh ***
`ifndef HRS_CONSTS_SVH
`define HRS_CONSTS_SVH
// record types
`define HRS_TYPE_DATA     8'h00
`define HRS_TYPE_EOF      8'h01
`define HRS_TYPE_FILENUM  8'h02
// characters
`define HRS_CHAR_COLON    8'h3A
`define HRS_CHAR_CTRLZ    8'h1A
`define HRS_CHAR_CR       8'h0D
`define HRS_CHAR_LF       8'h0A
// most data bytes in one record
`define HRS_MAX_DATA      5'h10
// user memory top address
`define HRS_USER_TOP      16'h7FFF
// timer reference and system clock, Hz
`define HRS_REF_HZ        6000000
`define HRS_SYS_HZ        200000000
// rate codes
`define HRS_RATE_RESET    3'h4
// character format bits: start, 8 data, stop
`define HRS_CHAR_BITS     4'hA
`endif

// *** core/hrs_pkg.sv ***
package hrs_pkg;
    // frame sequencer states
    typedef enum logic [3:0] {
        HRS_IDLE, HRS_MARK, HRS_HDR, HRS_DATA, HRS_SUM, HRS_CR, HRS_LF,
        HRS_EOFZ, HRS_DONE
    } hrs_state_t;

    // record kinds
    typedef enum logic [1:0] {
        HRS_REC_FNUM, HRS_REC_DATA, HRS_REC_EOF
    } hrs_rec_t;

    // line front end selection
    typedef enum logic {
        HRS_LINE_RS232, HRS_LINE_LOOP
    } hrs_line_t;
endpackage : hrs_pkg

// *** core/hrs_fifo.sv ***
`include "hrs_consts.svh"
module hrs_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             i_clk,      // system clock
    input  wire logic             i_rst_b,    // async reset, low
    input  wire logic [WIDTH-1:0] i_data,     // write data
    input  wire logic             i_valid,    // write request
    output logic                  o_ready,    // room available
    output logic [WIDTH-1:0]      o_data,     // head word
    output logic                  o_valid,    // not empty
    input  wire logic             i_ready     // reader takes head
);
    localparam int AW = $clog2(DEPTH);
    // whole state in one struct
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;   // storage
        logic [AW-1:0]               wp;    // write index
        logic [AW-1:0]               rp;    // read index
        logic [AW:0]                 cnt;   // fill level
    } hrs_fifo_st_t;
    hrs_fifo_st_t st, next_st;
    logic push, pop;

    assign o_ready = (st.cnt != DEPTH[AW:0]);
    assign o_valid = (st.cnt != '0);
    assign o_data  = st.mem[st.rp];
    assign push    = i_valid && o_ready;
    assign pop     = i_ready && o_valid;

    // pointer and level update
    always_comb
    begin
        next_st = st;
        if (push)
        begin
            next_st.mem[st.wp] = i_data;
            next_st.wp = (st.wp == AW'(DEPTH-1)) ? '0 : st.wp + 1'b1;
        end
        if (pop)
            next_st.rp = (st.rp == AW'(DEPTH-1)) ? '0 : st.rp + 1'b1;
        next_st.cnt = st.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end

    // registers
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            st <= '0;
        else
            st <= next_st;
    end
endmodule : hrs_fifo

// *** verif/hrs_upload_properties.sv ***
module hrs_upload_properties (
    input wire logic        i_clk,             // clock
    input wire logic        i_rst_b,           // reset, low
    input wire logic        i_start,           // upload pulse
    input wire logic [15:0] i_part_lo,         // first address
    input wire logic [15:0] i_part_hi,         // last address
    input wire logic        i_load_done,       // load end pulse
    input wire logic [15:0] i_load_exec,       // exec address
    input wire logic [15:0] o_program_counter, // program counter
    input wire logic        i_rate_wr,         // rate write
    input wire logic [2:0]  i_rate_sel,        // rate code in
    input wire logic [2:0]  o_rate_sel,        // rate code out
    input wire logic        o_list_mode,       // listing
    input wire logic        o_loading,         // busy
    input wire logic        o_bad_part,        // refused
    input wire logic        i_line_sel,        // line select
    input wire logic        o_txd_rs232        // rs-232 out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // an accepted start: idle and inside user memory
    wire go_ok = i_start && !o_loading && i_part_hi <= 16'h7FFF && i_part_lo <= i_part_hi;
    property p_rst_rate; $rose(i_rst_b) |-> o_rate_sel == 3'h4; endproperty
    a_rst_rate: assert property (p_rst_rate) else $error("rate after reset wrong");
    property p_rate_ok; i_rate_wr && i_rate_sel <= 3'h6 |=> o_rate_sel == $past(i_rate_sel); endproperty
    a_rate_ok: assert property (p_rate_ok) else $error("rate not read back");
    property p_rate7; i_rate_wr && i_rate_sel == 3'h7 |=> $stable(o_rate_sel); endproperty
    a_rate7: assert property (p_rate7) else $error("illegal rate taken");
    property p_list; go_ok |=> !o_list_mode; endproperty
    a_list: assert property (p_list) else $error("listing kept on");
    property p_load; go_ok |=> o_loading [*3]; endproperty
    a_load: assert property (p_load) else $error("loading not shown");
    property p_bad; i_start && !o_loading && i_part_hi > 16'h7FFF |=> o_bad_part && !o_loading; endproperty
    a_bad: assert property (p_bad) else $error("bad partition taken");
    property p_pc; i_load_done |=> o_program_counter == $past(i_load_exec); endproperty
    a_pc: assert property (p_pc) else $error("program counter not loaded");
    property p_line; i_line_sel && $past(i_line_sel) |-> o_txd_rs232; endproperty
    a_line: assert property (p_line) else $error("unselected line not high");
endmodule : hrs_upload_properties

// *** verif/hrs_host_model.sv ***
module hrs_host_model (
    input  wire logic i_txd,   // device serial out
    input  wire logic i_bclk,  // 16x bit clock
    input  wire logic i_ready, // copy utility running
    output logic      o_cts_b, // clear to send, low
    output logic [3:0] o_nbits, // bits taken
    output logic [9:0] o_bits   // bits, first in lsb
);
    timeunit 1ns;
    timeprecision 1ps;
    // grant only once the copy runs, so nothing is lost
    assign o_cts_b = !i_ready;
    initial o_nbits = 4'h0;
    initial o_bits = 10'h3FF;
    // mid-bit sampling: 8 ticks into start, then 16 per bit
    always
    begin
        @(negedge i_txd);
        for (int b = 0; b < 10; b++)
        begin
            repeat ((b == 0) ? 8 : 16) @(posedge i_bclk);
            o_bits[b] = i_txd;
            o_nbits = 4'(b + 1);
        end
    end
endmodule : hrs_host_model

// *** verif/tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_clk = 1'b0;   // system clock
    logic        i_rst_b = 1'b0; // reset, low
    logic        start = 1'b0, list_on = 1'b0, rate_wr = 1'b0, load_done = 1'b0;
    logic        line = 1'b0, eng = 1'b0, itx = 1'b1, hs = 1'b0, ready = 1'b0;
    logic [2:0]  rate = 3'h0;    // rate code
    logic [15:0] exec = 16'h0, pc = 16'h0, hi = 16'h0;
    wire logic [15:0] addr, prog;
    wire logic [2:0]  rsel;
    wire logic [3:0]  nbits;
    wire logic [9:0]  bits;
    wire logic        list, rts_b, tx232, txloop, bclk, loading, bad, cts_b;
    int          n_fail = 0;     // mismatches
    int          checked = 0;    // comparisons
    int          ncyc = 0;       // cycle count
    always #2.5 i_clk = ~i_clk;
    always @(posedge i_clk) ncyc <= ncyc + 1;
    // memory content made from the address, so it is never constant
    hrs_upload u_hrs_upload (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_start(start), .i_cassette(1'b0),
        .i_file_num(16'h0005), .i_part_lo(16'h0100), .i_part_hi(hi), .i_pc(pc), .o_mem_addr(addr),
        .i_mem_data(addr[7:0] ^ 8'hA5), .i_load_done(load_done), .i_load_exec(exec),
        .o_program_counter(prog), .i_list_on(list_on), .o_list_mode(list), .i_rate_wr(rate_wr),
        .i_rate_sel(rate), .o_rate_sel(rsel), .i_line_sel(line), .i_engine_sel(eng), .i_int_txd(itx),
        .i_ext_hs(hs), .i_cts_b(cts_b), .o_rts_b(rts_b), .o_txd_rs232(tx232), .o_txd_loop(txloop),
        .o_bit_rate_clock(bclk), .o_loading(loading), .o_bad_part(bad));
    hrs_host_model u_hrs_host_model (.i_txd(tx232), .i_bclk(bclk), .i_ready(ready), .o_cts_b(cts_b),
        .o_nbits(nbits), .o_bits(bits));
    task automatic complete_run;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask : cyc
    // bounded wait for a bit clock level; a hang ends the run
    task automatic wait_bclk(input logic v);
        int lim;
        lim = 0;
        while (bclk !== v && lim < 9000)
        begin
            cyc(1);
            lim++;
        end
        if (lim >= 9000)
        begin
            chk(16'h1, 16'h0);
            complete_run();
        end
    endtask : wait_bclk
    // every code written and read back, code 7 refused
    task automatic t_rates;
        chk(rsel, 16'h4);
        for (int c = 0; c < 8; c++)
        begin
            rate = 3'(c);
            rate_wr = 1'b1;
            cyc(1);
            rate_wr = 1'b0;
            cyc(1);
            chk(rsel, (c == 7) ? 16'h6 : 16'(c));
        end
    endtask : t_rates
    // one 16x period measured after a new rate, within 5 percent
    task automatic t_bitclk(input logic [2:0] code, input int baud);
        int t0, per;
        rate = code;
        rate_wr = 1'b1;
        cyc(1);
        rate_wr = 1'b0;
        t0 = 0;
        for (int k = 0; k < 3; k++)
        begin
            wait_bclk(1'b0);
            wait_bclk(1'b1);
            if (k == 1)
                t0 = ncyc;
        end
        per = (ncyc - t0) * 100 / (200000000 / (baud * 16));
        chk(16'(per >= 95 && per <= 105), 16'h1);
    endtask : t_bitclk
    task automatic t_pc;
        pc = 16'h1234;
        cyc(2);
        exec = 16'h0ABC;
        load_done = 1'b1;
        cyc(1);
        load_done = 1'b0;
        chk(prog, 16'h0ABC);
    endtask : t_pc
    task automatic t_bad;
        hi = 16'h8000;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        chk({bad, loading}, 16'h2);
    endtask : t_bad
    // host holds clear-to-send off first: nothing may leave meanwhile
    task automatic t_upload;
        int lim;
        hs = 1'b1;
        hi = 16'h0120;
        list_on = 1'b1;
        cyc(1);
        list_on = 1'b0;
        start = 1'b1;
        cyc(1);
        start = 1'b0;
        chk({loading, list}, 16'h2);
        chk(addr, 16'h0100);
        cyc(2000);
        chk({tx232, rts_b, nbits}, 16'h20);
        ready = 1'b1;
        lim = 0;
        while (nbits < 4'h3 && lim < 95000)
        begin
            cyc(1);
            lim++;
        end
        if (lim >= 95000)
        begin
            chk(16'h1, 16'h0);
            complete_run();
        end
        chk({loading, bits[2:0]}, 16'hC);
    endtask : t_upload
    task automatic t_engine;
        eng = 1'b1;
        itx = 1'b0;
        cyc(5);
        chk(tx232, 16'h0);
        line = 1'b1;
        cyc(5);
        chk({tx232, txloop}, 16'h2);
    endtask : t_engine
    initial
    begin
        cyc(8);
        i_rst_b = 1'b1;
        cyc(1);
        t_rates();
        t_bitclk(3'h6, 9600);
        t_bitclk(3'h5, 4800);
        rate = 3'h6;
        rate_wr = 1'b1;
        cyc(1);
        rate_wr = 1'b0;
        t_pc();
        t_bad();
        t_upload();
        t_engine();
        complete_run();
    end
endmodule : tb
bind hrs_upload hrs_upload_properties u_hrs_upload_properties (.i_clk, .i_rst_b, .i_start, .i_part_lo,
    .i_part_hi, .i_load_done, .i_load_exec, .o_program_counter, .i_rate_wr, .i_rate_sel, .o_rate_sel,
    .o_list_mode, .o_loading, .o_bad_part, .i_line_sel, .o_txd_rs232);
